// ==== dv/bsi_top_properties.sv ====
// concurrent checks on the pins of bsi_top
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module bsi_chk
#(
   parameter [16:0] FAILSAFE_CYC = 17'h101d0
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hwrite,
   input wire logic descIrq,
   input wire logic irqLogged,
   input wire logic cmdValidAny,
   input wire logic cmdValidOwn,
   input wire logic cmdServiced,
   input wire logic rtModeOut,
   input wire logic chanUsedA,
   input wire logic bitFailDet,
   input wire logic txBusyA,
   input wire logic subsystem_fail,
   input wire logic external_override_n,
   input wire logic stsSubsysFlag,
   input wire logic std_irq_level_n,
   input wire logic std_irq_pulse_n,
   input wire logic high_prio_irq_n,
   input wire logic tx_on_chan_a_n,
   input wire logic tx_on_chan_b_n,
   input wire logic tx_a_true,
   input wire logic tx_a_comp,
   input wire logic tx_b_true,
   input wire logic tx_b_comp,
   input wire logic bus_active,
   input wire logic cmd_strobe_n,
   input wire logic selftest_fail,
   input wire logic chan_a_not_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // length of the current low stretch of channel A transmitter-on
   logic [16:0] runA_q;
   always @(posedge clk)
      if (!rst_n || tx_on_chan_a_n) runA_q <= 17'h0;
      else runA_q <= runA_q + 17'h1;
   irq_level_set_a: assert property (descIrq |=> !std_irq_level_n)
      else $error("std level not set");
   level_hold_a: assert property (
      $rose(std_irq_level_n) |-> $past(hwrite, 2))
      else $error("std level released without write");
   pulse_event_a: assert property (irqLogged |=> !std_irq_pulse_n)
      else $error("no std pulse");
   pulse_cause_a: assert property (!std_irq_pulse_n |-> $past(irqLogged))
      else $error("std pulse too long");
   hp_release_a: assert property (
      $rose(high_prio_irq_n) |-> $past(hwrite, 2))
      else $error("hp released without write");
   txon_start_a: assert property (
      $rose(txBusyA) && external_override_n |=> !tx_on_chan_a_n)
      else $error("tx on not driven");
   txon_bound_a: assert property (runA_q < FAILSAFE_CYC)
      else $error("fail-safe overrun");
   idle_low_a: assert property (
      !(tx_on_chan_a_n && (tx_a_true || tx_a_comp)) &&
      !(tx_on_chan_b_n && (tx_b_true || tx_b_comp)))
      else $error("tx line not idle low");
   active_set_a: assert property (cmdValidAny |=> bus_active)
      else $error("activity not shown");
   strobe_set_a: assert property (
      cmdValidOwn && rtModeOut |=> !cmd_strobe_n)
      else $error("strobe not set");
   strobe_clear_a: assert property (
      cmdServiced && !cmdValidOwn |=> cmd_strobe_n)
      else $error("strobe not cleared");
   fail_out_a: assert property (bitFailDet |=> selftest_fail)
      else $error("self-test fail not shown");
   chan_ind_a: assert property (chanUsedA |=> chan_a_not_b)
      else $error("channel A not shown");
   subsys_pass_a: assert property (
      subsystem_fail [*6] |-> stsSubsysFlag)
      else $error("subsystem fail not passed");
endmodule // bsi_chk
bind bsi_top bsi_chk #(.FAILSAFE_CYC(FAILSAFE_CYC)) chk (.*);
`default_nettype wire

// ==== dv/bsi_top_tb_top.sv ====
// self-checking bench for bsi_top
// assumes 100 MHz clock, fail-safe shortened to 40 cycles
`timescale 1ns/100ps
`default_nettype none
module bsi_top_tb_top;
   localparam int FS = 40;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, nbrStrobe_n = 1;
   logic txBusyA = 0, encTrueA = 0, encCompA = 0, bitFailDet = 0;
   logic txBusyB = 0, encTrueB = 0, encCompB = 0, subsystem_fail = 0;
   logic [31:0] haddr = 0, hwdata = 0, r;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [7:0]  pv = 0;
   logic [15:0] stdEvent = 0;
   logic [15:1] hpEvent = 0;
   int          mismatches = 0, checks = 0, cyc = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, rxTrueA, rxCompA, rxTrueB, rxCompB;
   wire overrideAbort, rtModeOut, stsSubsysFlag, stsTermFlag;
   wire rx_a_true, rx_a_comp, rx_b_true, rx_b_comp, external_override_n;
   wire std_irq_level_n, std_irq_pulse_n, high_prio_irq_n, bus_active;
   wire tx_on_chan_a_n, tx_on_chan_b_n, cmd_strobe_n, selftest_fail;
   wire tx_a_true, tx_a_comp, tx_b_true, tx_b_comp, chan_a_not_b;
   wire hready = hreadyout;
   wire descIrq = pv[7], irqLogged = pv[6], cmdValidAny = pv[5];
   wire cmdValidOwn = pv[4], cmdServiced = pv[3], msgDone = pv[2];
   wire chanUsedA = pv[1], chanUsedB = pv[0];
   wire [9:0] rstVec = {std_irq_level_n, std_irq_pulse_n, high_prio_irq_n,
      tx_on_chan_a_n, tx_on_chan_b_n, cmd_strobe_n, chan_a_not_b,
      bus_active, selftest_fail, hreadyout};
   wire [4:0] rowOut = {std_irq_level_n, std_irq_pulse_n, bus_active,
      cmd_strobe_n, chan_a_not_b};
   // pulse byte, then {level_n, pulse_n, active, strobe_n, chan}
   logic [12:0] rows [8] = '{
      {8'h80, 5'b01011},
      {8'h40, 5'b00011},
      {8'h20, 5'b01111},
      {8'h04, 5'b01011},
      {8'h01, 5'b01010},
      {8'h03, 5'b01011},
      {8'h10, 5'b01001},
      {8'h08, 5'b01011}};
   bsi_top #(.FAILSAFE_CYC(17'h28)) DUT (.*);
   bsi_xcvr_model xcvr (.clk(clk), .txOnA_n(tx_on_chan_a_n),
      .txTrueA(tx_a_true), .txCompA(tx_a_comp), .txOnB_n(tx_on_chan_b_n),
      .txTrueB(tx_b_true), .txCompB(tx_b_comp), .nbrStrobe_n(nbrStrobe_n),
      .rxTrueA(rx_a_true), .rxCompA(rx_a_comp), .rxTrueB(rx_b_true),
      .rxCompB(rx_b_comp), .extOverride_n(external_override_n));
   initial forever #5 clk = ~clk;
   task summarize;
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task cmp(input logic [31:0] e, input logic [31:0] a);
      checks++;
      if (a !== e)
      begin
         mismatches++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   // one single word transfer; the slave's wait states end every wait
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches++;
         summarize();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      #1 cmp(10'h3f9, rstVec);
      bus(1, 8'h00, 32'h1);
      foreach (rows[i])
      begin
         @(posedge clk) pv <= rows[i][12:5];
         @(posedge clk) pv <= 0;
         #1 cmp(rows[i][4:0], rowOut);
      end
      cmp(2'h2, {rtModeOut, hresp});
      bus(1, 8'h08, 32'h8);
      @(posedge clk) hpEvent[3] <= 1;
      @(posedge clk) hpEvent <= 0;
      #1 cmp(0, high_prio_irq_n);
      bus(0, 8'h0c, 0);
      cmp(32'h9, r);
      bus(1, 8'h0c, 32'h8);
      @(posedge clk);
      #1 cmp(2'b10, {high_prio_irq_n, std_irq_level_n});
      bus(1, 8'h0c, 32'h1);
      @(posedge clk) #1 cmp(1, std_irq_level_n);
      bus(1, 8'h04, 32'h4);
      @(posedge clk) stdEvent <= 16'h2;
      @(posedge clk) stdEvent <= 0;
      #1 cmp(1, std_irq_level_n);
      @(posedge clk) stdEvent <= 16'h4;
      @(posedge clk) stdEvent <= 0;
      #1 cmp(0, std_irq_level_n);
      bus(1, 8'h1c, 32'hffff);
      bus(0, 8'h1c, 0);
      cmp(0, r);
      @(posedge clk) {txBusyA, encTrueA} <= 2'b11;
      @(posedge clk);
      #1 cmp(3'b010, {tx_on_chan_a_n, tx_a_true, tx_a_comp});
      // last driven cycle, then the fail-safe edge itself
      repeat (FS - 2) @(posedge clk);
      #1 cmp(3'b010, {tx_on_chan_a_n, rxTrueA, rxCompA});
      @(posedge clk);
      #1 cmp(3'b100, {tx_on_chan_a_n, tx_a_true, tx_a_comp});
      @(posedge clk) {txBusyA, encTrueA} <= 2'b00;
      bus(0, 8'h10, 0);
      cmp(1, r[7]);
      @(posedge clk) {txBusyB, encCompB} <= 2'b11;
      repeat (30) @(posedge clk);
      txBusyB <= 0;
      repeat (3) @(posedge clk);
      #1 cmp(3'b100, {tx_on_chan_b_n, tx_b_true, tx_b_comp});
      @(posedge clk) txBusyB <= 1;
      repeat (30) @(posedge clk);
      #1 cmp(3'b001, {tx_on_chan_b_n, tx_b_true, tx_b_comp});
      #1 cmp(2'b01, {rxTrueB, rxCompB});
      @(posedge clk) {txBusyB, encCompB} <= 2'b00;
      @(posedge clk) {subsystem_fail, bitFailDet} <= 2'b11;
      repeat (8) @(posedge clk);
      #1;
      cmp(3'h7, {stsSubsysFlag,selftest_fail,stsTermFlag});
      bus(0, 8'h10, 0);
      cmp(32'h3, r & 32'h3);
      bus(1, 8'h00, 0);
      repeat (2) @(posedge clk);
      #1 cmp(0, stsTermFlag);
      @(posedge clk) {subsystem_fail, bitFailDet, pv} <= 10'h020;
      @(posedge clk) {pv, nbrStrobe_n} <= 9'h0;
      repeat (8) @(posedge clk);
      #1 cmp(2'b10, {overrideAbort, bus_active});
      @(posedge clk) nbrStrobe_n <= 1;
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      #1 cmp(10'h3f9, rstVec);
      bus(0, 8'h04, 0);
      cmp(0, r);
      summarize();
   end
endmodule // bsi_top_tb_top
`default_nettype wire

// ==== dv/bsi_xcvr_model.sv ====
// transceivers of both channels and the neighbour device's strobe
// assumes pins sampled and driven on the block clock
`timescale 1ns/100ps
`default_nettype none
module bsi_xcvr_model
(
   input  wire logic clk,
   input  wire logic txOnA_n,
   input  wire logic txTrueA,
   input  wire logic txCompA,
   input  wire logic txOnB_n,
   input  wire logic txTrueB,
   input  wire logic txCompB,
   input  wire logic nbrStrobe_n,
   output var  logic rxTrueA,
   output var  logic rxCompA,
   output var  logic rxTrueB,
   output var  logic rxCompB,
   output var  logic extOverride_n
);
   initial {rxTrueA, rxCompA, rxTrueB, rxCompB, extOverride_n} = 5'h1;
   // receivers echo our own transmission; a quiet bus reads both low
   always @(posedge clk)
   begin
      rxTrueA <= !txOnA_n && txTrueA;
      rxCompA <= !txOnA_n && txCompA;
      rxTrueB <= !txOnB_n && txTrueB;
      rxCompB <= !txOnB_n && txCompB;
      extOverride_n <= nbrStrobe_n;
   end
endmodule // bsi_xcvr_model
`default_nettype wire

// ==== rtl/bsi_defines.vh ====
// constants of the bus status, interrupt and biphase pin block
// assumes a 100 MHz clock and a 32-bit AHB-Lite register bus
//
// Notes on behaviour
// - enabled standard events assert standard level interrupt
// - level holds until host resets standard bit
// - every logged interrupt pulses standard pulse output
// - enabled high-priority events assert high-priority interrupt
// - host reset of status bits releases it
// - transmitter-on low while channel transmits
// - fail-safe timer drops transmitter-on after 660us
// - activity high on valid command, any address
// - RT command strobe low until command serviced
// - subsystem failure passes straight to status
// - self-test failure output follows built-in test
// - RT mode: self-test failure sets terminal flag
// - channel indicator: high A, low B, last used
// - both transmit lines low when not transmitting
// - each channel drives true/complement Manchester pair
// - each channel receives true/complement Manchester pair
`ifndef BSI_DEFINES_VH
`define BSI_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BSI_OFF_CTRL    8'h00
`define BSI_OFF_STDEN   8'h04
`define BSI_OFF_HPEN    8'h08
`define BSI_OFF_HPSTAT  8'h0c
`define BSI_OFF_STATUS  8'h10

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define BSI_CTRL_RTMODE 0
`define BSI_HP_STDBIT   0
`define BSI_ST_SSF      0
`define BSI_ST_BITF     1
`define BSI_ST_CHAN     2
`define BSI_ST_TXONA    3
`define BSI_ST_TXONB    4
`define BSI_ST_ACT      5
`define BSI_ST_STROBE   6
`define BSI_ST_TMOA     7
`define BSI_ST_TMOB     8
`define BSI_ST_TERMF    9
`define BSI_RST_CTRL    1'h0
`define BSI_RST_EN      16'h0000
`define BSI_RST_HPSTAT  16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BSI_CLK_NS      10
`define BSI_FAILSAFE_NS 660000
// 660 us of 10 ns cycles, sized to the timer width
`define BSI_FAILSAFE_CYC 17'h101d0

`endif

// ==== rtl/bsi_rx_sync.v ====
// three-stage synchroniser with agreement filter for one pin
// assumes an asynchronous pin and the block clock
`timescale 1ns/100ps
`default_nettype none
module bsi_rx_sync
#(
   parameter [0:0] INIT = 1'h0
)
(
   input  wire clk,
   input  wire rst_n,
   input  wire pinIn,
   output reg  pinOut
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // s1 feeds only s2; the value moves once s2 and s3 agree
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_q   <= INIT;
         s2_q   <= INIT;
         s3_q   <= INIT;
         pinOut <= INIT;
      end
      else
      begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            pinOut <= s3_q;
      end
   end
endmodule // bsi_rx_sync
`default_nettype wire

// ==== rtl/bsi_top.v ====
// status, interrupt and biphase pin logic with AHB-Lite registers
// assumes the protocol core supplies event pulses and encoder bits
// on clk, and that the bus has this block as its only slave
`timescale 1ns/100ps
`default_nettype none
`include "bsi_defines.vh"
module bsi_top
#(
   parameter [16:0] FAILSAFE_CYC = `BSI_FAILSAFE_CYC
)
(
   input  wire        clk,
   input  wire        rst_n,
   // register bus
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // events from the protocol core
   input  wire [15:0] stdEvent,
   input  wire        descIrq,
   input  wire        irqLogged,
   input  wire [15:1] hpEvent,
   input  wire        cmdValidAny,
   input  wire        cmdValidOwn,
   input  wire        cmdServiced,
   input  wire        msgDone,
   input  wire        chanUsedA,
   input  wire        chanUsedB,
   input  wire        bitFailDet,
   input  wire        txBusyA,
   input  wire        encTrueA,
   input  wire        encCompA,
   input  wire        txBusyB,
   input  wire        encTrueB,
   input  wire        encCompB,
   // to the protocol core
   output wire        rxTrueA,
   output wire        rxCompA,
   output wire        rxTrueB,
   output wire        rxCompB,
   output reg         overrideAbort,
   output reg         rtModeOut,
   output reg         stsSubsysFlag,
   output reg         stsTermFlag,
   // device pins
   input  wire        rx_a_true,
   input  wire        rx_a_comp,
   input  wire        rx_b_true,
   input  wire        rx_b_comp,
   input  wire        subsystem_fail,
   input  wire        external_override_n,
   output reg         std_irq_level_n,
   output reg         std_irq_pulse_n,
   output reg         high_prio_irq_n,
   output wire        tx_on_chan_a_n,
   output wire        tx_on_chan_b_n,
   output wire        tx_a_true,
   output wire        tx_a_comp,
   output wire        tx_b_true,
   output wire        tx_b_comp,
   output reg         bus_active,
   output reg         cmd_strobe_n,
   output reg         selftest_fail,
   output reg         chan_a_not_b
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire ssfS;
   wire ovrS_n;
   wire [3:0] rxPins = {rx_b_comp, rx_b_true, rx_a_comp, rx_a_true};
   wire [3:0] rxS;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_rx
         bsi_rx_sync #(.INIT(1'h0)) u_rx
         (
            .clk    (clk),
            .rst_n  (rst_n),
            .pinIn  (rxPins[g]),
            .pinOut (rxS[g])
         );
      end
   endgenerate

   assign rxTrueA = rxS[0];
   assign rxCompA = rxS[1];
   assign rxTrueB = rxS[2];
   assign rxCompB = rxS[3];

   bsi_rx_sync #(.INIT(1'h0)) u_ssf
   (
      .clk    (clk),
      .rst_n  (rst_n),
      .pinIn  (subsystem_fail),
      .pinOut (ssfS)
   );

   bsi_rx_sync #(.INIT(1'h1)) u_ovr
   (
      .clk    (clk),
      .rst_n  (rst_n),
      .pinIn  (external_override_n),
      .pinOut (ovrS_n)
   );

   // ----------------------------------------------------------------
   // transmit channels
   // ----------------------------------------------------------------
   wire abortNow = ~ovrS_n;
   wire tmoA;
   wire tmoB;

   bsi_tx_guard #(.FAILSAFE_CYC(FAILSAFE_CYC)) u_txa
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .txBusy   (txBusyA),
      .encTrue  (encTrueA),
      .encComp  (encCompA),
      .abort    (abortNow),
      .txOn_n   (tx_on_chan_a_n),
      .txTrue   (tx_a_true),
      .txComp   (tx_a_comp),
      .timedOut (tmoA)
   );

   bsi_tx_guard #(.FAILSAFE_CYC(FAILSAFE_CYC)) u_txb
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .txBusy   (txBusyB),
      .encTrue  (encTrueB),
      .encComp  (encCompB),
      .abort    (abortNow),
      .txOn_n   (tx_on_chan_b_n),
      .txTrue   (tx_b_true),
      .txComp   (tx_b_comp),
      .timedOut (tmoB)
   );

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   reg        ctrl_q;
   reg [15:0] stdEn_q;
   reg [15:1] hpEn_q;
   reg [15:0] hpStat_q;
   reg        tmoA_q;
   reg        tmoB_q;
   reg        wrPend_q;
   reg        rdPend_q;
   reg [7:0]  addr_q;

   wire addrPhase = hsel & htrans[1] & hready;
   wire wrNow     = wrPend_q;
   wire [15:0] hpClr =
      (wrNow && hit(addr_q, `BSI_OFF_HPSTAT)) ? hwdata[15:0] : 16'h0000;

   wire [31:0] statusWord = {22'h000000,
      stsTermFlag, tmoB_q, tmoA_q, ~cmd_strobe_n, bus_active,
      ~tx_on_chan_b_n, ~tx_on_chan_a_n, chan_a_not_b, selftest_fail,
      stsSubsysFlag};

   reg [31:0] rdMux;
   always @*
   begin
      rdMux = 32'h00000000;
      if (hit(addr_q, `BSI_OFF_CTRL))
         rdMux = {31'h00000000, ctrl_q};
      else if (hit(addr_q, `BSI_OFF_STDEN))
         rdMux = {16'h0000, stdEn_q};
      else if (hit(addr_q, `BSI_OFF_HPEN))
         rdMux = {16'h0000, hpEn_q, 1'h0};
      else if (hit(addr_q, `BSI_OFF_HPSTAT))
         rdMux = {16'h0000, hpStat_q};
      else if (hit(addr_q, `BSI_OFF_STATUS))
         rdMux = statusWord;
   end

   // reads take one wait state so a read right after a write sees it
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPend_q  <= 1'h0;
         rdPend_q  <= 1'h0;
         addr_q    <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'h1;
         hresp     <= 1'h0;
         ctrl_q    <= `BSI_RST_CTRL;
         stdEn_q   <= `BSI_RST_EN;
         hpEn_q    <= 15'h0000;
      end
      else
      begin
         hresp    <= 1'h0;
         wrPend_q <= addrPhase & hwrite;
         if (addrPhase)
            addr_q <= {haddr[7:2], 2'h0};
         if (addrPhase && !hwrite)
         begin
            rdPend_q  <= 1'h1;
            hreadyout <= 1'h0;
         end
         else if (rdPend_q)
         begin
            rdPend_q  <= 1'h0;
            hreadyout <= 1'h1;
            hrdata    <= rdMux;
         end
         if (wrNow && hit(addr_q, `BSI_OFF_CTRL))
            ctrl_q <= hwdata[`BSI_CTRL_RTMODE];
         if (wrNow && hit(addr_q, `BSI_OFF_STDEN))
            stdEn_q <= hwdata[15:0];
         if (wrNow && hit(addr_q, `BSI_OFF_HPEN))
            hpEn_q <= hwdata[15:1];
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   wire        stdSet = (|(stdEvent & stdEn_q)) | descIrq;
   wire [15:0] hpSet  = {hpEvent & hpEn_q, stdSet};
   // a new event in the clearing cycle survives: set wins
   wire [15:0] hpNext = (hpStat_q & ~hpClr) | hpSet;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         hpStat_q        <= `BSI_RST_HPSTAT;
         std_irq_level_n <= 1'h1;
         high_prio_irq_n <= 1'h1;
         std_irq_pulse_n <= 1'h1;
         tmoA_q          <= 1'h0;
         tmoB_q          <= 1'h0;
      end
      else
      begin
         hpStat_q        <= hpNext;
         std_irq_level_n <= ~hpNext[`BSI_HP_STDBIT];
         high_prio_irq_n <= ~(|hpNext[15:1]);
         std_irq_pulse_n <= ~irqLogged;
         if (tmoA)
            tmoA_q <= 1'h1;
         else if (wrNow && hit(addr_q, `BSI_OFF_STATUS) &&
                  hwdata[`BSI_ST_TMOA])
            tmoA_q <= 1'h0;
         if (tmoB)
            tmoB_q <= 1'h1;
         else if (wrNow && hit(addr_q, `BSI_OFF_STATUS) &&
                  hwdata[`BSI_ST_TMOB])
            tmoB_q <= 1'h0;
      end
   end

   // ----------------------------------------------------------------
   // status pins
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         bus_active    <= 1'h0;
         cmd_strobe_n  <= 1'h1;
         selftest_fail <= 1'h0;
         chan_a_not_b  <= 1'h1;
         stsSubsysFlag <= 1'h0;
         stsTermFlag   <= 1'h0;
         overrideAbort <= 1'h0;
         rtModeOut     <= 1'h0;
      end
      else
      begin
         rtModeOut     <= ctrl_q;
         overrideAbort <= abortNow;
         if (cmdValidAny)
            bus_active <= 1'h1;
         else if (msgDone || abortNow)
            bus_active <= 1'h0;
         // a new command beats the end of the old one in one cycle
         if (ctrl_q && cmdValidOwn && !abortNow)
            cmd_strobe_n <= 1'h0;
         else if (cmdServiced || abortNow || !ctrl_q)
            cmd_strobe_n <= 1'h1;
         selftest_fail <= bitFailDet;
         stsTermFlag   <= bitFailDet & ctrl_q;
         stsSubsysFlag <= ssfS;
         if (chanUsedA)
            chan_a_not_b <= 1'h1;
         else if (chanUsedB)
            chan_a_not_b <= 1'h0;
      end
   end

endmodule // bsi_top
`default_nettype wire

// ==== rtl/bsi_tx_guard.v ====
// one channel's transmit gate with fail-safe timer
// assumes encoder busy and Manchester bits on the block clock
`timescale 1ns/100ps
`default_nettype none
`include "bsi_defines.vh"
module bsi_tx_guard
#(
   parameter [16:0] FAILSAFE_CYC = `BSI_FAILSAFE_CYC
)
(
   input  wire clk,
   input  wire rst_n,
   input  wire txBusy,
   input  wire encTrue,
   input  wire encComp,
   input  wire abort,
   output reg  txOn_n,
   output reg  txTrue,
   output reg  txComp,
   output reg  timedOut
);
   reg  [16:0] cnt_q;
   reg         busy_q;
   reg         expired_q;
   wire        start   = txBusy & ~busy_q;
   // a fresh start never counts as expiry, whatever the stale count holds
   wire        hitEnd  = txBusy & ~start &
                         (cnt_q == FAILSAFE_CYC - 17'h00001);
   wire        drive   = txBusy & ~expired_q & ~hitEnd & ~abort;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_q     <= 17'h00000;
         busy_q    <= 1'h0;
         expired_q <= 1'h0;
         txOn_n    <= 1'h1;
         txTrue    <= 1'h0;
         txComp    <= 1'h0;
         timedOut  <= 1'h0;
      end
      else
      begin
         busy_q <= txBusy;
         if (start)
            cnt_q <= 17'h00001;
         else if (txBusy && !expired_q)
            cnt_q <= cnt_q + 17'h00001;
         // latch expiry so a stuck encoder cannot re-key the bus
         if (!txBusy)
            expired_q <= 1'h0;
         else if (hitEnd && !start)
            expired_q <= 1'h1;
         timedOut <= hitEnd & ~start & ~expired_q;
         txOn_n   <= ~drive;
         txTrue   <= drive & encTrue;
         txComp   <= drive & encComp;
      end
   end
endmodule // bsi_tx_guard
`default_nettype wire
